// file: include/bsr_pkg.sv
// package for the bus status code reporter: offsets, codes, timings
// assumes a single 10 MHz pclk domain and an APB register port
package bsr_pkg;

  // clock and microsecond tick
  localparam int          BSR_CLK_PERIOD_NS = 100;
  localparam int          BSR_NS_PER_US     = 1000;
  localparam int          BSR_TICK_CYCLES   = BSR_NS_PER_US / BSR_CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0]  BSR_OFS_CMD      = 8'h00;
  localparam logic [7:0]  BSR_OFS_STATUS   = 8'h04;
  localparam logic [7:0]  BSR_OFS_CTRL     = 8'h08;
  localparam logic [7:0]  BSR_OFS_TXDATA   = 8'h0C;
  localparam logic [7:0]  BSR_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0]  BSR_OFS_IRQ_MASK = 8'h14;

  // field positions
  localparam int          BSR_ST_SLAVE_LSB  = 0;
  localparam int          BSR_ST_MASTER_LSB = 4;
  localparam int          BSR_ST_SLAVE_TX_REQUEST_FLAG_BIT   = 8;
  localparam int          BSR_ST_TXFULL_BIT = 9;
  localparam int          BSR_CTRL_MODE_BIT = 0;
  localparam int          BSR_CTRL_MRX_BIT  = 1;
  localparam int          BSR_IRQ_SLAVE_BIT  = 0;
  localparam int          BSR_IRQ_MASTER_BIT = 1;

  // commands, control bits and status codes
  localparam logic [3:0]  BSR_CMD_SLV_TX_A = 4'hB;
  localparam logic [3:0]  BSR_CMD_SLV_TX_B = 4'hC;
  localparam logic [3:0]  BSR_CTL_DATA_A   = 4'h3;
  localparam logic [3:0]  BSR_CTL_DATA_B   = 4'h7;
  localparam logic [3:0]  BSR_SC_START     = 4'h0;
  localparam logic [3:0]  BSR_SC_NO_DATA   = 4'h1;
  localparam logic [3:0]  BSR_SC_DONE      = 4'h2;
  localparam logic [3:0]  BSR_SC_ABORT     = 4'h3;
  localparam logic [3:0]  BSR_SC_RESET     = 4'hF;
  localparam logic [3:0]  BSR_MC_RESET     = 4'hF;

  // minimum code spacing in microseconds, master transmission
  localparam logic [12:0] BSR_TX_GAP_M0 [0:6] =
    '{13'd2430, 13'd90, 13'd4710, 13'd6290, 13'd20, 13'd1570, 13'd7150};
  localparam logic [12:0] BSR_TX_GAP_M1 [0:6] =
    '{13'd740, 13'd90, 13'd1170, 13'd1570, 13'd20, 13'd390, 13'd1920};
  // minimum code spacing in microseconds, master reception
  localparam logic [12:0] BSR_RX_GAP_M0 [0:4] =
    '{13'd7150, 13'd90, 13'd1570, 13'd20, 13'd2430};
  localparam logic [12:0] BSR_RX_GAP_M1 [0:4] =
    '{13'd1920, 13'd90, 13'd390, 13'd20, 13'd740};
  // refill window after the data-unavailable code
  localparam logic [12:0] BSR_REFILL_US_M0 = 13'd1570;
  localparam logic [12:0] BSR_REFILL_US_M1 = 13'd390;

  typedef enum logic [1:0] {
    BSR_IDLE  = 2'b00,
    BSR_ARMED = 2'b01,
    BSR_SEND  = 2'b11,
    BSR_WAIT  = 2'b10
  } bsr_state_t;

  // spacing that must precede a master code at the given position
  function automatic logic [12:0] bsr_min_gap(input logic       rx,
                                              input logic       mode,
                                              input logic [2:0] idx);
    logic [2:0] ri;
    ri = (idx > 3'd4) ? 3'd4 : idx;
    if (rx)
      bsr_min_gap = mode ? BSR_RX_GAP_M1[ri] : BSR_RX_GAP_M0[ri];
    else if (idx == 3'd7)
      bsr_min_gap = mode ? BSR_TX_GAP_M1[6] : BSR_TX_GAP_M0[6];
    else
      bsr_min_gap = mode ? BSR_TX_GAP_M1[idx] : BSR_TX_GAP_M0[idx];
  endfunction

endpackage

// file: core/bsr_reporter.sv
// bus status code reporter: slave transmit sequencing and code spacing
// assumes frame logic on the same pclk drives the link-side strobes
//
// Operation
// - command 1011 or 1100 arms slave transmit
// - data-request control bits publish start code 0000
// - missing next byte publishes code 0001
// - full count sent gives 0010, clears flag
// - early end gives 0011, clears flag
// - master transmit codes keep minimum spacing
// - master receive codes keep minimum spacing
// - one readable slave code field, separate
//
// Local design decisions: register access over APB and the register addresses.

`timescale 1ns/1ps
`default_nettype none

module bsr_reporter
  import bsr_pkg::*;
#(
  parameter int TICK_CYCLES = BSR_TICK_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link side, frame logic on pclk
  input  wire logic        ctrl_valid,
  input  wire logic [3:0]  ctrl_bits,
  input  wire logic [7:0]  data_length,
  input  wire logic        byte_req,
  output logic             tx_byte_valid,
  output logic [7:0]       tx_byte,
  input  wire logic        frame_end,
  input  wire logic        master_code_valid,
  input  wire logic [3:0]  master_code,
  input  wire logic [2:0]  master_gap_sel,
  output logic             slave_tx_request_flag,
  output logic             irq
);

  if (TICK_CYCLES < 1 || TICK_CYCLES > 4096) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  //////////////////////////////////////////////////////////////////////////
  // register state
  logic [3:0]  command_code_field;
  logic [3:0]  slave_status_code;
  logic [3:0]  master_status_code;
  logic        mode;
  logic        master_rx;
  logic [7:0]  tx_hold;
  logic        tx_hold_full;
  logic [1:0]  irq_stat;
  logic [1:0]  irq_mask;
  bsr_state_t  state;
  bsr_state_t  next_state;
  logic [7:0]  len;
  logic [7:0]  sent;

  //////////////////////////////////////////////////////////////////////////
  // apb decode
  wire         acc       = psel & penable;
  wire         wr        = acc & pwrite;
  wire         hit_cmd   = (paddr == BSR_OFS_CMD);
  wire         hit_stat  = (paddr == BSR_OFS_STATUS);
  wire         hit_ctrl  = (paddr == BSR_OFS_CTRL);
  wire         hit_txd   = (paddr == BSR_OFS_TXDATA);
  wire         hit_ist   = (paddr == BSR_OFS_IRQ_STAT);
  wire         hit_imsk  = (paddr == BSR_OFS_IRQ_MASK);
  wire         mapped    = hit_cmd | hit_stat | hit_ctrl | hit_txd |
                           hit_ist | hit_imsk;
  wire         wr_cmd    = wr & hit_cmd;
  wire         wr_ctrl   = wr & hit_ctrl;
  wire         wr_txd    = wr & hit_txd;
  wire         wr_ist    = wr & hit_ist;
  wire         wr_imsk   = wr & hit_imsk;
  wire         cmd_arm   = wr_cmd & ((pwdata[3:0] == BSR_CMD_SLV_TX_A) |
                                     (pwdata[3:0] == BSR_CMD_SLV_TX_B));

  // zero-wait slave; only unmapped offsets raise an error
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // read mux, unused bits read as zero
  wire  [31:0] status_word = {22'h0, tx_hold_full, slave_tx_request_flag,
                              master_status_code, slave_status_code};
  wire  [31:0] rd_mux =
    hit_cmd  ? {28'h0, command_code_field} :
    hit_stat ? status_word :
    hit_ctrl ? {30'h0, master_rx, mode} :
    hit_ist  ? {30'h0, irq_stat} :
    hit_imsk ? {30'h0, irq_mask} :
    32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0;
    else if (clk_en && psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  //////////////////////////////////////////////////////////////////////////
  // microsecond tick shared by spacing and refill timers
  logic [12:0] tick_cnt;
  wire         us_tick = (tick_cnt == 13'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tick_cnt <= 13'h0;
    else if (clk_en)
      tick_cnt <= us_tick ? 13'h0 : tick_cnt + 13'h1;
  end

  //////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      command_code_field <= 4'h0;
      mode               <= 1'b0;
      master_rx          <= 1'b0;
      irq_mask           <= 2'h0;
    end else if (clk_en) begin
      if (wr_cmd)
        command_code_field <= pwdata[3:0];
      if (wr_ctrl) begin
        mode      <= pwdata[BSR_CTRL_MODE_BIT];
        master_rx <= pwdata[BSR_CTRL_MRX_BIT];
      end
      if (wr_imsk)
        irq_mask <= pwdata[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // slave transmit sequencer
  wire         data_req  = ctrl_valid & ((ctrl_bits == BSR_CTL_DATA_A) |
                                         (ctrl_bits == BSR_CTL_DATA_B));
  wire         in_frame  = (state == BSR_SEND) | (state == BSR_WAIT);
  wire         all_sent  = (sent == len);
  // byte taken now: a pending request, or a late refill while waiting
  wire         take_byte = tx_hold_full &
                           ((state == BSR_SEND & byte_req) |
                            (state == BSR_WAIT));
  wire         starve    = (state == BSR_SEND) & byte_req & ~tx_hold_full;
  logic [12:0] refill_us;
  wire  [12:0] refill_lim = mode ? BSR_REFILL_US_M1 : BSR_REFILL_US_M0;
  // the host gets the full window; after it the device gives up
  wire         refill_out = (state == BSR_WAIT) & ~tx_hold_full &
                            (refill_us >= refill_lim);
  wire         finish     = in_frame & (frame_end | refill_out);
  // new slave code and its value, one per cycle at most
  logic        sc_event;
  logic [3:0]  sc_value;
  always_comb begin
    next_state = state;
    sc_event   = 1'b0;
    sc_value   = slave_status_code;
    unique case (state)
      BSR_IDLE: begin
        if (slave_tx_request_flag)
          next_state = BSR_ARMED;
      end
      BSR_ARMED: begin
        if (data_req) begin
          next_state = BSR_SEND;
          sc_event   = 1'b1;
          sc_value   = BSR_SC_START;
        end
      end
      BSR_SEND: begin
        if (finish) begin
          next_state = BSR_IDLE;
          sc_event   = 1'b1;
          sc_value   = all_sent ? BSR_SC_DONE : BSR_SC_ABORT;
        end else if (starve) begin
          next_state = BSR_WAIT;
          sc_event   = 1'b1;
          sc_value   = BSR_SC_NO_DATA;
        end
      end
      BSR_WAIT: begin
        if (finish) begin
          next_state = BSR_IDLE;
          sc_event   = 1'b1;
          sc_value   = all_sent ? BSR_SC_DONE : BSR_SC_ABORT;
        end else if (take_byte) begin
          next_state = BSR_SEND;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      state <= BSR_IDLE;
    else if (clk_en)
      state <= next_state;
  end

  // flag: a command arms it, the end of a transmit frame drops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      slave_tx_request_flag <= 1'b0;
    else if (clk_en) begin
      if (cmd_arm)
        slave_tx_request_flag <= 1'b1;
      else if (finish)
        slave_tx_request_flag <= 1'b0;
    end
  end

  // byte counter and frame length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len  <= 8'h0;
      sent <= 8'h0;
    end else if (clk_en) begin
      if (state == BSR_ARMED && data_req) begin
        len  <= data_length;
        sent <= 8'h0;
      end else if (take_byte && !all_sent)
        sent <= sent + 8'h1;
    end
  end

  // refill window timer, runs only while starved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      refill_us <= 13'h0;
    else if (clk_en) begin
      if (state != BSR_WAIT)
        refill_us <= 13'h0;
      else if (us_tick && refill_us != 13'h1FFF)
        refill_us <= refill_us + 13'h1;
    end
  end

  // one-byte hold; a write while full is dropped, software checks txfull
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold      <= 8'h0;
      tx_hold_full <= 1'b0;
    end else if (clk_en) begin
      if (wr_txd && !tx_hold_full) begin
        tx_hold      <= pwdata[7:0];
        tx_hold_full <= 1'b1;
      end else if (take_byte)
        tx_hold_full <= 1'b0;
    end
  end

  // byte toward the link, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_byte       <= 8'h0;
      tx_byte_valid <= 1'b0;
    end else if (clk_en) begin
      tx_byte_valid <= take_byte;
      if (take_byte)
        tx_byte <= tx_hold;
    end
  end

  // each new slave code overwrites the last one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      slave_status_code <= BSR_SC_RESET;
    else if (clk_en && sc_event)
      slave_status_code <= sc_value;
  end

  //////////////////////////////////////////////////////////////////////////
  // master code spacing: codes are held back until the gap has run
  logic        mc_pend;
  logic [3:0]  mc_hold;
  logic [2:0]  mc_sel;
  logic [12:0] gap_us;
  wire  [12:0] gap_need = bsr_min_gap(master_rx, mode, mc_sel);
  wire         mc_pub   = mc_pend & (gap_us >= gap_need);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_pend <= 1'b0;
      mc_hold <= 4'h0;
      mc_sel  <= 3'h0;
    end else if (clk_en) begin
      if (master_code_valid) begin
        mc_pend <= 1'b1;
        mc_hold <= master_code;
        mc_sel  <= master_gap_sel;
      end else if (mc_pub)
        mc_pend <= 1'b0;
    end
  end

  // time since last published code, saturating; starts saturated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      gap_us <= 13'h1FFF;
    else if (clk_en) begin
      if (mc_pub)
        gap_us <= 13'h0;
      else if (us_tick && gap_us != 13'h1FFF)
        gap_us <= gap_us + 13'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      master_status_code <= BSR_MC_RESET;
    else if (clk_en && mc_pub)
      master_status_code <= mc_hold;
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, write one to clear, a new event beats the clear
  wire  [1:0]  irq_set = {mc_pub, sc_event};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      irq_stat <= 2'h0;
    else if (clk_en)
      irq_stat <= (irq_stat & ~(wr_ist ? pwdata[1:0] : 2'h0)) |
                  irq_set;
  end

  assign irq = |(irq_stat & irq_mask);

endmodule

`default_nettype wire

// file: sim/bsr_reporter_checker.sv
// checker: port-level properties of the status code reporter
// assumes one pclk domain; a write counts only while clk_en is high
`timescale 1ns/1ps
`default_nettype none
module bsr_reporter_checker
  import bsr_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        byte_req,
  input wire logic        tx_byte_valid,
  input wire logic        slave_tx_request_flag,
  input wire logic        irq
);
  ////////////////////////////////////////
  // decoded apb accesses
  wire acc   = psel && penable;
  wire wr    = acc && pwrite && clk_en; // frozen writes are lost
  wire arm   = wr && paddr == BSR_OFS_CMD &&
    pwdata[3:0] inside {BSR_CMD_SLV_TX_A, BSR_CMD_SLV_TX_B};
  wire wr_tx = wr && paddr == BSR_OFS_TXDATA;
  wire rd_st = acc && !pwrite && paddr == BSR_OFS_STATUS;
  wire bad   = acc && paddr > BSR_OFS_IRQ_MASK;
  logic [1:0] msk;

  // mask shadow, so irq can be tied to what software enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msk <= 2'h0;
    end else if (wr && paddr == BSR_OFS_IRQ_MASK) begin
      msk <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_arm_cause: assert property (
    $rose(slave_tx_request_flag) |-> $past(arm))
    else $error("flag rose without an arming write");
  a_arm_take: assert property (
    arm |=> slave_tx_request_flag)
    else $error("arming write did not set the flag");
  a_byte_cause: assert property (
    tx_byte_valid |-> $past(byte_req) || $past(wr_tx, 2))
    else $error("byte sent without request or refill");
  a_byte_armed: assert property (
    tx_byte_valid |-> $past(slave_tx_request_flag))
    else $error("byte sent with the flag clear");
  a_status_view: assert property (
    rd_st |-> prdata[8] == $past(slave_tx_request_flag) &&
      prdata[31:10] == 22'h0)
    else $error("status word does not match the flag");
  a_map_error: assert property (
    bad |-> pslverr && (pwrite || prdata == 32'h0)) // writes keep prdata
    else $error("unmapped access not refused");
  a_err_access: assert property (
    pslverr |-> acc)
    else $error("error outside an access phase");
  a_irq_masked: assert property (
    irq |-> msk != 2'h0)
    else $error("irq high with every source masked");

  // main scenarios
  c_byte: cover property (tx_byte_valid);
  c_finish: cover property ($fell(slave_tx_request_flag));
  c_irq: cover property (irq && rd_st);
endmodule

bind bsr_reporter bsr_reporter_checker u_chk (
  .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pslverr, .byte_req, .tx_byte_valid, .slave_tx_request_flag,
  .irq
);
`default_nettype wire

// file: sim/bsr_link_model.sv
// link model: the bus master opposite our slave transmitter
// assumes the reporter's link strobes run on the same pclk
`timescale 1ns/1ps
`default_nettype none
module bsr_link_model (
  input  wire logic       pclk,
  output logic            ctrl_valid,
  output logic [3:0]      ctrl_bits,
  output logic [7:0]      data_length,
  output logic            byte_req,
  input  wire logic       tx_byte_valid,
  input  wire logic [7:0] tx_byte,
  output logic            frame_end,
  output logic            master_code_valid,
  output logic [3:0]      master_code,
  output logic [2:0]      master_gap_sel
);
  logic [7:0] got = 8'h00;
  int         n_got = 0;

  // quiet link at time zero
  initial begin
    {ctrl_valid, byte_req, frame_end, master_code_valid} = 4'h0;
    {ctrl_bits, data_length, master_code, master_gap_sel} = 19'h0;
  end

  // collect every byte the reporter puts on the link
  always @(posedge pclk) begin
    if (tx_byte_valid === 1'h1) begin
      got <= tx_byte;
      n_got <= n_got + 1;
    end
  end

  // control bits asking for data, with the frame's byte count
  task automatic ctl(input logic [3:0] b, input logic [7:0] n);
    @(posedge pclk);
    ctrl_valid <= 1'h1;
    ctrl_bits <= b;
    data_length <= n;
    @(posedge pclk);
    ctrl_valid <= 1'h0;
    ctrl_bits <= ~b; // released lines must not keep the old value
    data_length <= ~n;
  endtask

  // one byte request, a one-cycle pulse; the caller waits for the byte
  task automatic pull;
    @(posedge pclk);
    byte_req <= 1'h1;
    @(posedge pclk);
    byte_req <= 1'h0;
  endtask

  // end of communication, normal or early
  task automatic fin;
    @(posedge pclk);
    frame_end <= 1'h1;
    @(posedge pclk);
    frame_end <= 1'h0;
  endtask

  // master code with the index of the gap before it
  task automatic mcode(input logic [3:0] c, input logic [2:0] s);
    @(posedge pclk);
    master_code_valid <= 1'h1;
    master_code <= c;
    master_gap_sel <= s;
    @(posedge pclk);
    master_code_valid <= 1'h0;
    master_code <= ~c;
    master_gap_sel <= ~s;
  endtask
endmodule
`default_nettype wire

// file: sim/tb_bus_status_code_reporter.sv
// testbench for the status code reporter, link model on the far side
// assumes TICK_CYCLES of 1, so a gap of n microseconds is n cycles
`timescale 1ns/1ps
`default_nettype none
module tb_bus_status_code_reporter;
  import bsr_pkg::*;
  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] ctl;
    logic [7:0] len;
    logic [7:0] nb;
    logic [3:0] sc;
  } bsr_row_t;
  typedef struct packed {
    logic [1:0]  ctl;
    logic [2:0]  sel;
    logic [12:0] us;
  } bsr_gap_t;
  // arming command, control bits, length, bytes sent, final code
  bsr_row_t rows [4] = '{'{4'hB, 4'h3, 8'h01, 8'h01, 4'h2},
    '{4'hC, 4'h7, 8'h02, 8'h02, 4'h2}, '{4'hB, 4'h7, 8'h03, 8'h01, 4'h3},
    '{4'hC, 4'h3, 8'h00, 8'h00, 4'h2}};
  // mode and receive select, gap index, spacing in microseconds
  bsr_gap_t gaps [5] = '{'{2'h0, 3'h3, 13'h1892}, '{2'h1, 3'h2, 13'h492},
    '{2'h2, 3'h4, 13'h97E}, '{2'h3, 3'h0, 13'h780}, '{2'h0, 3'h4, 13'h14}};
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        clk_en = 1'h1;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic [7:0]  data_length, tx_byte;
  logic [3:0]  ctrl_bits, master_code;
  logic [2:0]  master_gap_sel;
  logic        pready, pslverr, ctrl_valid, byte_req, tx_byte_valid, err;
  logic        frame_end, master_code_valid, slave_tx_request_flag, irq;
  int          n_fail = 0;
  int          comparisons = 0;

  always #50 pclk = ~pclk;

  bsr_reporter #(.TICK_CYCLES(1)) u_dut (.clk_en, .pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ctrl_valid, .ctrl_bits, .data_length, .byte_req, .tx_byte_valid,
    .tx_byte, .frame_end, .master_code_valid, .master_code,
    .master_gap_sel, .slave_tx_request_flag, .irq);
  bsr_link_model link (.pclk, .ctrl_valid, .ctrl_bits, .data_length,
    .byte_req, .tx_byte_valid, .tx_byte, .frame_end, .master_code_valid,
    .master_code, .master_gap_sel);

  ////////////////////////////////////////
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; no fixed latency assumed, pready decides
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // load one byte, optionally request it, wait for it on the link
  task automatic send_byte(input logic [7:0] b, input logic p);
    int n0;
    n0 = link.n_got;
    apb(1'h1, BSR_OFS_TXDATA, 32'(b));
    if (p) begin
      link.pull();
    end
    for (int k = 0; k < 8 && link.n_got == n0; k++) @(posedge pclk);
    chk("tx byte", 32'(b), 32'(link.got));
  endtask

  // a hang ends here rather than running on
  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    give_verdict();
  end

  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, BSR_OFS_STATUS, 32'h0);
    chk("status reset", 32'hFF, rd);
    apb(1'h0, 8'h18, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    apb(1'h1, 8'h18, 32'h1);
    chk("unmapped write", 32'h1, 32'(err));
    apb(1'h1, BSR_OFS_IRQ_MASK, 32'h1);
    apb(1'h0, BSR_OFS_IRQ_MASK, 32'h0);
    chk("mask", 32'h1, rd);
    foreach (rows[i]) begin
      apb(1'h1, BSR_OFS_CMD, 32'(rows[i].cmd));
      apb(1'h0, BSR_OFS_STATUS, 32'h0);
      chk("armed", 32'h1, 32'(rd[8]));
      chk("flag pin", 32'h1, 32'(slave_tx_request_flag));
      link.ctl(rows[i].ctl, rows[i].len);
      apb(1'h0, BSR_OFS_STATUS, 32'h0);
      chk("start code", 32'h0, 32'(rd[3:0]));
      chk("irq", 32'h1, 32'(irq));
      apb(1'h1, BSR_OFS_IRQ_STAT, 32'h1);
      for (int j = 0; j < rows[i].nb; j++) send_byte(8'hA0 + 8'(j), 1'h1);
      link.fin();
      apb(1'h0, BSR_OFS_STATUS, 32'h0);
      chk("end code", 32'(rows[i].sc), 32'(rd[3:0]));
      chk("end flag", 32'h0, 32'(rd[8]));
      apb(1'h1, BSR_OFS_IRQ_STAT, 32'h1);
    end
    // late refill in mode 1 still completes the frame
    apb(1'h1, BSR_OFS_CTRL, 32'h1);
    apb(1'h1, BSR_OFS_CMD, 32'hB);
    link.ctl(4'h3, 8'h01);
    link.pull();
    apb(1'h0, BSR_OFS_STATUS, 32'h0);
    chk("no data code", 32'h1, 32'(rd[3:0]));
    send_byte(8'h5A, 1'h0);
    link.fin();
    apb(1'h0, BSR_OFS_STATUS, 32'h0);
    chk("refill end", 32'h2, 32'(rd[3:0]));
    // no refill within 390 cycles aborts; irq masked meanwhile
    apb(1'h1, BSR_OFS_IRQ_MASK, 32'h0);
    apb(1'h1, BSR_OFS_CMD, 32'hC);
    link.ctl(4'h7, 8'h01);
    link.pull();
    repeat (370) @(posedge pclk);
    apb(1'h0, BSR_OFS_STATUS, 32'h0);
    chk("still waiting", 32'h1, 32'(rd[3:0]));
    chk("masked irq", 32'h0, 32'(irq));
    repeat (40) @(posedge pclk);
    apb(1'h0, BSR_OFS_STATUS, 32'h0);
    chk("timeout code", 32'h3, 32'(rd[3:0]));
    chk("timeout flag", 32'h0, 32'(rd[8]));
    apb(1'h1, BSR_OFS_IRQ_MASK, 32'h1);
    @(posedge pclk);
    chk("unmasked irq", 32'h1, 32'(irq));
    apb(1'h1, BSR_OFS_IRQ_STAT, 32'h3);
    @(posedge pclk);
    chk("cleared irq", 32'h0, 32'(irq));
    // frozen clock enable: the write is lost, every register holds
    clk_en <= 1'h0;
    apb(1'h1, BSR_OFS_IRQ_MASK, 32'h0);
    clk_en <= 1'h1;
    apb(1'h0, BSR_OFS_IRQ_MASK, 32'h0);
    chk("frozen mask", 32'h1, rd);
    // a new master code waits out the spacing after the last one
    foreach (gaps[i]) begin
      apb(1'h1, BSR_OFS_CTRL, 32'(gaps[i].ctl));
      link.mcode(4'(2 * i), 3'h4);
      for (int k = 0; k < 3000 && rd[7:4] !== 4'(2 * i); k++) begin
        apb(1'h0, BSR_OFS_STATUS, 32'h0);
      end
      link.mcode(4'(2 * i + 1), gaps[i].sel);
      repeat (gaps[i].us - 12) @(posedge pclk);
      apb(1'h0, BSR_OFS_STATUS, 32'h0);
      chk("code held", 32'(2 * i), 32'(rd[7:4]));
      repeat (20) @(posedge pclk);
      apb(1'h0, BSR_OFS_STATUS, 32'h0);
      chk("code moved", 32'(2 * i + 1), 32'(rd[7:4]));
    end
    // reset in mid-run brings codes, flag and mask back to start values
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, BSR_OFS_STATUS, 32'h0);
    chk("status rerun", 32'hFF, rd);
    apb(1'h0, BSR_OFS_IRQ_MASK, 32'h0);
    chk("mask rerun", 32'h0, rd);
    give_verdict();
  end
endmodule
`default_nettype wire
